// *** verilog/rbt_pkg.sv ***
// shared constants of the registered bus transceiver
package rbt_pkg;

  // width of each direction register
  localparam int DATA_W = 8;

  // register byte offsets, decoded on the low address bits
  localparam int ADDR_DEC_W = 4;
  localparam logic [ADDR_DEC_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_DEC_W-1:0] OFS_AB_DATA = 4'h4;
  localparam logic [ADDR_DEC_W-1:0] OFS_BA_DATA = 4'h8;
  localparam logic [ADDR_DEC_W-1:0] OFS_PIN_STAT = 4'hC;

  // control register fields
  localparam int CTRL_W = 2;
  localparam int CTRL_INV_AB_BIT = 0;
  localparam int CTRL_INV_BA_BIT = 1;

  // pin status register fields
  localparam int STAT_W = 6;
  localparam int STAT_AB_CEN_BIT = 0;
  localparam int STAT_BA_CEN_BIT = 1;
  localparam int STAT_B_DEN_BIT = 2;
  localparam int STAT_A_DEN_BIT = 3;
  localparam int STAT_B_OE_BIT = 4;
  localparam int STAT_A_OE_BIT = 5;

  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : rbt_pkg

// *** verilog/rbt_sync.sv ***
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps

module rbt_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  // meta_ff feeds sync_ff only
  always_comb
  begin
    nxt_meta = d;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= RST;
      sync_ff <= RST;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign q = sync_ff;

endmodule : rbt_sync

// *** verilog/rbt_dir.sv ***
// one direction of the transceiver: capture register and output driver
`timescale 1ns/1ps

module rbt_dir #(
  parameter int W = rbt_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cap_edge,
  input wire logic cap_en_n,
  input wire logic drive_en_n,
  input wire logic invert,
  input wire logic [W-1:0] din,
  output logic [W-1:0] store_q,
  output logic [W-1:0] pin_out,
  output logic pin_oe
);
  import rbt_pkg::*;

  logic [W-1:0] q_ff;
  logic [W-1:0] out_ff;
  logic oe_ff;
  logic [W-1:0] nxt_q;
  logic [W-1:0] nxt_out;
  logic nxt_oe;

  always_comb
  begin
    nxt_q = q_ff; // R04
    if (cap_edge && !cap_en_n)
    begin
      nxt_q = din; // R03
    end
    // built from nxt_q so the pins never lag the store by a cycle
    nxt_out = nxt_q ^ {W{invert}}; // R06 R07
    nxt_oe = !drive_en_n; // R05
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_ff <= W'(DATA_RST);
      out_ff <= W'(DATA_RST);
      oe_ff <= 1'b0;
    end
    else
    begin
      q_ff <= nxt_q;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
    end
  end

  assign store_q = q_ff;
  assign pin_out = out_ff;
  assign pin_oe = oe_ff;

endmodule : rbt_dir

// *** verilog/rbt_top.sv ***
// registered bidirectional bus transceiver with an ahb-lite control slave
//
// Notes on behaviour
// R01 - two separate 8-bit stores: A-to-B and B-to-A.
// R02 - each direction has its own capture clock, capture enable and drive enable.
// R03 - rising capture clock with capture enable low loads the input port.
// R04 - capture enable high keeps the stored value whatever clock or data do.
// R05 - drive enable high releases the output port.
// R06 - drive enable low drives the stored value; true level when not inverting.
// R07 - inverting variant drives the complement; storage and enables unchanged.
// R08 - B-to-A path behaves exactly like A-to-B with its own controls.
// R09 - outside parties keep off a port while its drive enable is low.
`timescale 1ns/1ps

module rbt_top #(
  parameter int DW = rbt_pkg::DATA_W,
  parameter logic INVERTING = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic a_to_b_capture_clock,
  input wire logic b_to_a_capture_clock,
  input wire logic a_to_b_capture_enable_n,
  input wire logic b_to_a_capture_enable_n,
  input wire logic b_port_drive_enable_n,
  input wire logic a_port_drive_enable_n,
  input wire logic [DW-1:0] port_a_lines_in,
  output logic [DW-1:0] port_a_lines_out,
  output logic port_a_lines_oe,
  input wire logic [DW-1:0] port_b_lines_in,
  output logic [DW-1:0] port_b_lines_out,
  output logic port_b_lines_oe
);
  import rbt_pkg::*;

  localparam int SW = 2 * DW + 6;
  // enables are active low: they reset released so no port drives early
  localparam logic [SW-1:0] SYNC_RST = {{(2 * DW + 2){1'b0}}, 4'hF};

  // synchronised pin levels
  logic [SW-1:0] pins_s;
  logic [DW-1:0] a_data_s;
  logic [DW-1:0] b_data_s;
  logic ab_clk_s;
  logic ba_clk_s;
  logic ab_cen_s;
  logic ba_cen_s;
  logic b_den_s;
  logic a_den_s;

  // capture clock edge detection
  logic [1:0] clk_prev_ff;
  logic [1:0] nxt_clk_prev;
  logic ab_edge;
  logic ba_edge;

  // direction stores
  logic [DW-1:0] ab_q;
  logic [DW-1:0] ba_q;

  // bus slave state
  logic addr_acc;
  logic dp_wr_ff;
  logic [ADDR_DEC_W-1:0] dp_addr_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [31:0] hrdata_ff;
  logic nxt_dp_wr;
  logic [ADDR_DEC_W-1:0] nxt_dp_addr;
  logic [CTRL_W-1:0] nxt_ctrl;
  logic [31:0] nxt_hrdata;
  logic [STAT_W-1:0] pin_stat;

  // every pin level crosses two flops; data and clocks see equal delay
  rbt_sync #(
    .W(SW),
    .RST(SYNC_RST)
  ) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({port_a_lines_in, port_b_lines_in, a_to_b_capture_clock, b_to_a_capture_clock,
        a_to_b_capture_enable_n, b_to_a_capture_enable_n, b_port_drive_enable_n,
        a_port_drive_enable_n}),
    .q(pins_s)
  );

  assign a_data_s = pins_s[SW-1 -: DW];
  assign b_data_s = pins_s[SW-DW-1 -: DW];
  assign ab_clk_s = pins_s[5];
  assign ba_clk_s = pins_s[4];
  assign ab_cen_s = pins_s[3];
  assign ba_cen_s = pins_s[2];
  assign b_den_s = pins_s[1];
  assign a_den_s = pins_s[0];

  always_comb
  begin
    nxt_clk_prev = {ba_clk_s, ab_clk_s};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_prev_ff <= 2'h0;
    end
    else
    begin
      clk_prev_ff <= nxt_clk_prev;
    end
  end

  // rising edges only; a pin pulse shorter than one hclk period may be missed
  assign ab_edge = ab_clk_s & ~clk_prev_ff[0]; // R03
  assign ba_edge = ba_clk_s & ~clk_prev_ff[1]; // R08

  // a to b: loads from port A, drives port B
  rbt_dir #(
    .W(DW)
  ) u_ab (
    .clk(hclk),
    .rst_n(hresetn),
    .cap_edge(ab_edge),
    .cap_en_n(ab_cen_s),
    .drive_en_n(b_den_s),
    .invert(ctrl_ff[CTRL_INV_AB_BIT]),
    .din(a_data_s),
    .store_q(ab_q),
    .pin_out(port_b_lines_out),
    .pin_oe(port_b_lines_oe)
  ); // R01 R02

  // b to a: same block, own controls
  rbt_dir #(
    .W(DW)
  ) u_ba (
    .clk(hclk),
    .rst_n(hresetn),
    .cap_edge(ba_edge),
    .cap_en_n(ba_cen_s),
    .drive_en_n(a_den_s),
    .invert(ctrl_ff[CTRL_INV_BA_BIT]),
    .din(b_data_s),
    .store_q(ba_q),
    .pin_out(port_a_lines_out),
    .pin_oe(port_a_lines_oe)
  ); // R01 R02 R08

  // pin status as software sees it
  always_comb
  begin
    pin_stat = '0;
    pin_stat[STAT_AB_CEN_BIT] = ab_cen_s;
    pin_stat[STAT_BA_CEN_BIT] = ba_cen_s;
    pin_stat[STAT_B_DEN_BIT] = b_den_s;
    pin_stat[STAT_A_DEN_BIT] = a_den_s;
    pin_stat[STAT_B_OE_BIT] = port_b_lines_oe;
    pin_stat[STAT_A_OE_BIT] = port_a_lines_oe;
  end

  assign addr_acc = hsel && hready && htrans[1];

  always_comb
  begin
    nxt_dp_wr = addr_acc && hwrite && (hsize == HSIZE_WORD);
    nxt_dp_addr = addr_acc ? haddr[ADDR_DEC_W-1:0] : dp_addr_ff;
    nxt_ctrl = ctrl_ff;
    if (dp_wr_ff && (dp_addr_ff == OFS_CTRL))
    begin
      nxt_ctrl = hwdata[CTRL_W-1:0]; // R07
    end
    nxt_hrdata = hrdata_ff;
    if (addr_acc && !hwrite)
    begin
      // nxt_ctrl so a read right after a write returns the new value
      unique case (haddr[ADDR_DEC_W-1:0])
        OFS_CTRL: nxt_hrdata = {{(32 - CTRL_W){1'b0}}, nxt_ctrl};
        OFS_AB_DATA: nxt_hrdata = {{(32 - DW){1'b0}}, ab_q};
        OFS_BA_DATA: nxt_hrdata = {{(32 - DW){1'b0}}, ba_q};
        OFS_PIN_STAT: nxt_hrdata = {{(32 - STAT_W){1'b0}}, pin_stat};
        default: nxt_hrdata = RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_ff <= 1'b0;
      dp_addr_ff <= OFS_CTRL;
      ctrl_ff <= {CTRL_W{INVERTING}};
      hrdata_ff <= RDATA_RST;
    end
    else
    begin
      dp_wr_ff <= nxt_dp_wr;
      dp_addr_ff <= nxt_dp_addr;
      ctrl_ff <= nxt_ctrl;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // zero wait states, never an error
  assign hreadyout = 1'b1;
  assign hrdata = hrdata_ff;
  assign hresp = HRESP_OKAY;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_ab_load;
    ab_edge && !ab_cen_s;
  endsequence

  sequence s_ba_load;
    ba_edge && !ba_cen_s;
  endsequence

  sequence s_ab_pin_rise;
    !a_to_b_capture_clock ##1 a_to_b_capture_clock ##1 a_to_b_capture_clock;
  endsequence

  sequence s_ba_pin_rise;
    !b_to_a_capture_clock ##1 b_to_a_capture_clock ##1 b_to_a_capture_clock;
  endsequence

  a_both_stores: assert property ( // R01
    (s_ab_load and s_ba_load) |=> (ab_q == $past(a_data_s)) && (ba_q == $past(b_data_s)))
    else $error("stores did not take both port values");

  a_ab_isolated: assert property ( // R02
    (ab_edge && !ba_edge) |=> $stable(ba_q))
    else $error("b to a store moved on an a to b edge");

  a_ab_pin_edge: assert property ( // R03
    s_ab_pin_rise |=> ab_edge)
    else $error("a to b capture clock rise not seen after synchronising");

  a_ab_load: assert property ( // R03
    s_ab_load |=> (ab_q == $past(a_data_s)))
    else $error("a to b store missed a load");

  a_ab_hold: assert property ( // R04
    ab_cen_s |=> $stable(ab_q))
    else $error("a to b store changed while capture disabled");

  a_b_release: assert property ( // R05
    b_den_s |=> !port_b_lines_oe)
    else $error("port b driven while its drive enable is high");

  a_a_release: assert property ( // R05
    a_den_s |=> !port_a_lines_oe)
    else $error("port a driven while its drive enable is high");

  a_b_true_drive: assert property ( // R06
    (!b_den_s && !ctrl_ff[CTRL_INV_AB_BIT]) |=> port_b_lines_oe && (port_b_lines_out == ab_q))
    else $error("port b does not show the stored value");

  a_b_inv_drive: assert property ( // R07
    (!b_den_s && ctrl_ff[CTRL_INV_AB_BIT]) |=> port_b_lines_oe && (port_b_lines_out == ~ab_q))
    else $error("port b does not show the inverted store");

  a_a_inv_drive: assert property ( // R07
    (!a_den_s && ctrl_ff[CTRL_INV_BA_BIT]) |=> port_a_lines_oe && (port_a_lines_out == ~ba_q))
    else $error("port a does not show the inverted store");

  a_ba_pin_edge: assert property ( // R08
    s_ba_pin_rise |=> ba_edge)
    else $error("b to a capture clock rise not seen after synchronising");

  a_ba_load: assert property ( // R08
    s_ba_load |=> (ba_q == $past(b_data_s)))
    else $error("b to a store missed a load");

  a_ba_hold: assert property ( // R08
    ba_cen_s |=> $stable(ba_q))
    else $error("b to a store changed while capture disabled");

  a_a_true_drive: assert property ( // R08
    (!a_den_s && !ctrl_ff[CTRL_INV_BA_BIT]) |=> port_a_lines_oe && (port_a_lines_out == ba_q))
    else $error("port a does not show the stored value");

  a_ctrl_write: assert property ( // R07
    (dp_wr_ff && (dp_addr_ff == OFS_CTRL)) |=> (ctrl_ff == $past(hwdata[CTRL_W-1:0])))
    else $error("control write not taken");

endmodule : rbt_top

// *** testbench/rbt_far.sv ***
// far-side bus parties on ports a and b, with wire resolution
`timescale 1ns/1ps

module rbt_far (
  input wire logic clk,
  input wire logic [rbt_pkg::DATA_W-1:0] a_val,
  input wire logic a_drv,
  input wire logic [rbt_pkg::DATA_W-1:0] b_val,
  input wire logic b_drv,
  input wire logic [rbt_pkg::DATA_W-1:0] a_out,
  input wire logic a_oe,
  input wire logic [rbt_pkg::DATA_W-1:0] b_out,
  input wire logic b_oe,
  output logic [rbt_pkg::DATA_W-1:0] a_in,
  output logic [rbt_pkg::DATA_W-1:0] b_in
);
  import rbt_pkg::*;
  logic [DATA_W-1:0] a_last_ff = '0;
  logic [DATA_W-1:0] b_last_ff = '0;
  // far party yields while the device drives; a floating line shows the inverse
  always_comb
  begin
    a_in = a_oe ? a_out : (a_drv ? a_val : ~a_last_ff);
    b_in = b_oe ? b_out : (b_drv ? b_val : ~b_last_ff);
  end
  always_ff @(posedge clk)
  begin
    a_last_ff <= a_in;
    b_last_ff <= b_in;
  end
endmodule : rbt_far

// *** testbench/tb_rbt_top.sv ***
// self-checking bench for the registered bus transceiver
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("Error %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module tb_rbt_top;
  import rbt_pkg::*;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp;
  logic ab_ck, ba_ck, ab_en_n, ba_en_n, b_drv_n, a_drv_n;
  logic [7:0] a_in, a_out, b_in, b_out, a_val, b_val, base, got;
  logic a_oe, b_oe, a_drv, b_drv;
  logic [31:0] hrdata_i;
  logic [7:0] a_out_i, b_out_i;
  int err_count, cmp_count;

  rbt_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .a_to_b_capture_clock(ab_ck),
    .b_to_a_capture_clock(ba_ck), .a_to_b_capture_enable_n(ab_en_n),
    .b_to_a_capture_enable_n(ba_en_n), .b_port_drive_enable_n(b_drv_n),
    .a_port_drive_enable_n(a_drv_n), .port_a_lines_in(a_in), .port_a_lines_out(a_out),
    .port_a_lines_oe(a_oe), .port_b_lines_in(b_in), .port_b_lines_out(b_out),
    .port_b_lines_oe(b_oe));

  rbt_far far (.clk(hclk), .a_val(a_val), .a_drv(a_drv), .b_val(b_val), .b_drv(b_drv),
    .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .a_in(a_in), .b_in(b_in));

  // inverting variant sees the same bus and pins; only its outputs are checked
  rbt_top #(.INVERTING(1'b1)) uut_inv (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata_i), .hreadyout(), .hresp(),
    .a_to_b_capture_clock(ab_ck), .b_to_a_capture_clock(ba_ck),
    .a_to_b_capture_enable_n(ab_en_n), .b_to_a_capture_enable_n(ba_en_n),
    .b_port_drive_enable_n(b_drv_n), .a_port_drive_enable_n(a_drv_n),
    .port_a_lines_in(a_in), .port_a_lines_out(a_out_i), .port_a_lines_oe(),
    .port_b_lines_in(b_in), .port_b_lines_out(b_out_i), .port_b_lines_oe());

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // master never assumes a latency; hreadyout high ends the wait, this bound only catches a hung slave
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        err_count++;
        $display("Error hready timeout");
        finish_test();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  task automatic ahb(input logic wr, input logic [3:0] ofs, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {28'h0000000, ofs};
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
    `CHK("hresp", HRESP_OKAY, hresp)
  endtask : ahb

  task automatic cap(input int dir, input logic [7:0] d, input logic en_n);
    @(posedge hclk);
    if (dir == 0)
    begin
      a_val <= d;
      a_drv <= 1'b1;
      ab_en_n <= en_n;
    end
    else
    begin
      b_val <= d;
      b_drv <= 1'b1;
      ba_en_n <= en_n;
    end
    repeat (2) @(posedge hclk);
    if (dir == 0) ab_ck <= 1'b1;
    else ba_ck <= 1'b1;
    repeat (3) @(posedge hclk);
    ab_ck <= 1'b0;
    ba_ck <= 1'b0;
    repeat (4) @(posedge hclk);
    a_drv <= 1'b0;
    b_drv <= 1'b0;
    ab_en_n <= 1'b1;
    ba_en_n <= 1'b1;
  endtask : cap

  task automatic drive(input int dir, input logic v);
    @(posedge hclk);
    if (dir == 0) b_drv_n <= v;
    else a_drv_n <= v;
    repeat (4) @(posedge hclk);
    got = dir ? a_out : b_out;
  endtask : drive

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial
  begin
    {hresetn, hsel, hwrite, ab_ck, ba_ck, a_drv, b_drv} = '0;
    {ab_en_n, ba_en_n, b_drv_n, a_drv_n} = 4'hF;
    {haddr, hwdata, htrans, hsize, a_val, b_val} = '0;
    err_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h00000000, rv)
    `CHK("variant ctrl reset", 32'h00000003, hrdata_i)
    for (int dir = 0; dir < 2; dir++)
    begin
      base = dir ? 8'h3C : 8'hA5;
      cap(dir, base, 1'b0);
      ahb(1'b0, dir ? OFS_BA_DATA : OFS_AB_DATA, 32'h0);
      `CHK("store load", {24'h000000, base}, rv)
      cap(dir, ~base, 1'b1);
      ahb(1'b0, dir ? OFS_BA_DATA : OFS_AB_DATA, 32'h0);
      `CHK("store hold", {24'h000000, base}, rv)
      `CHK("oe idle", 1'b0, dir ? a_oe : b_oe)
      drive(dir, 1'b0);
      `CHK("oe on", 1'b1, dir ? a_oe : b_oe)
      `CHK("out true", base, got)
      `CHK("variant out", dir ? base : ~base, dir ? a_out_i : b_out_i)
      ahb(1'b0, OFS_PIN_STAT, 32'h0);
      `CHK("pin status", dir ? 32'h00000027 : 32'h0000001B, rv)
      ahb(1'b1, OFS_CTRL, dir ? 32'h2 : 32'h1);
      repeat (2) @(posedge hclk);
      got = dir ? a_out : b_out;
      `CHK("out inverted", ~base, got)
      ahb(1'b1, OFS_CTRL, 32'h0);
      drive(dir, 1'b1);
      `CHK("oe off", 1'b0, dir ? a_oe : b_oe)
      $display("test of direction %0d ended", dir);
    end
    ahb(1'b1, OFS_AB_DATA, 32'h000000FF);
    ahb(1'b0, OFS_AB_DATA, 32'h0);
    `CHK("ab store kept", 32'h000000A5, rv)
    ahb(1'b0, OFS_BA_DATA, 32'h0);
    `CHK("ba store kept", 32'h0000003C, rv)
    $display("test of independence ended");
    finish_test();
  end
endmodule : tb_rbt_top
